// ---- rtl/svc_pkg.sv ----
// Constants, register map and setting layout of the settings validity checker.
// Assumes a 200 MHz clock and a single-cycle register port with 8-bit byte addresses.
package svc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_POWER = 8'h0c;
  localparam logic [7:0] OFS_VOLT_W1 = 8'h10;
  localparam logic [7:0] OFS_VOLT_W2 = 8'h14;
  localparam logic [7:0] OFS_VOLT_W3 = 8'h18;
  localparam logic [7:0] OFS_CTPRI_W1 = 8'h1c;
  localparam logic [7:0] OFS_CTPRI_W2 = 8'h20;
  localparam logic [7:0] OFS_CTPRI_W3 = 8'h24;
  localparam logic [7:0] OFS_CT_SEC = 8'h28;
  localparam logic [7:0] OFS_ID0 = 8'h2c;
  localparam logic [7:0] OFS_ID2 = 8'h30;
  localparam logic [7:0] OFS_ID10 = 8'h34;
  localparam logic [7:0] OFS_EXT_ASSIGN = 8'h38;
  localparam logic [7:0] OFS_EXT_TMIN = 8'h3c;
  localparam logic [7:0] OFS_EXT_TMAX = 8'h40;

  // Field positions
  localparam int CTRL_THREE_WDG_BIT = 0;
  localparam int CTRL_REFUSE_BIT = 1;
  localparam int CMD_VALUE_EDITING_STATE_START_BIT = 0;
  localparam int CMD_VALUE_EDITING_STATE_EXIT_BIT = 1;
  localparam int CMD_STORE_KBD_BIT = 2;
  localparam int CMD_STORE_IFACE_BIT = 3;
  localparam int ST_EDITING_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_MSG_BIT = 2;
  localparam int ST_CODE_LSB = 4;
  localparam int ST_WDG_LSB = 8;
  localparam int ST_COMMITS_LSB = 16;
  localparam int EXT_TIME_EXIT_BIT = 15;
  localparam int EXT_ASSIGN_LOW_BIT = 0;
  localparam int EXT_ASSIGN_HIGH_BIT = 1;

  // Reset values of the settings
  localparam logic [19:0] RST_POWER_KVA = 20'h0439c;
  localparam logic [15:0] RST_VOLT_V = 16'h19c8;
  localparam logic [15:0] RST_CTPRI_A = 16'h05dc;
  localparam logic [7:0] RST_CT_SEC_A = 8'h01;
  localparam logic [11:0] RST_ID0 = 12'h014;
  localparam logic [11:0] RST_ID2 = 12'h028;
  localparam logic [11:0] RST_ID10 = 12'h0c8;
  localparam logic [1:0] RST_EXT_ASSIGN = 2'h3;
  localparam logic [9:0] RST_TMIN = 10'h001;
  localparam logic [9:0] RST_TMAX = 10'h014;

  // Check arithmetic: sqrt(3) in Q10, kVA to VA, Q10 scale
  localparam logic [47:0] SQRT3_Q10 = 48'h0000_0000_06ee;
  localparam logic [47:0] VA_PER_KVA_Q10 = 48'h0000_000f_a000;
  localparam logic [7:0] CT_SEC_LIMIT_A = 8'h05;

  // Timing: hold times count in steps of 0.1 s
  localparam int CLK_PERIOD_NS = 5;
  localparam int TIME_STEP_NS = 100_000_000;
  localparam int TICK_CYCLES = TIME_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ERR_NONE = 3'b000,
    ERR_CT_MISMATCH = 3'b001,
    ERR_CT_RATIO = 3'b010,
    ERR_VOLT_ORDER = 3'b011,
    ERR_CHARACTERISTIC = 3'b100,
    ERR_EXT_BLOCK = 3'b101
  } svc_err_e;

  typedef enum logic [1:0] {
    GRP_NONE = 2'b00,
    GRP_RATED = 2'b01,
    GRP_CHAR = 2'b10,
    GRP_EXT = 2'b11
  } svc_grp_e;

  typedef struct packed {
    logic [19:0] power;
    logic [2:0][15:0] volt;
    logic [2:0][15:0] ctpri;
    logic [7:0] ct_sec;
    logic [11:0] id0;
    logic [11:0] id2;
    logic [11:0] id10;
    logic [1:0] ext_assign;
    logic [9:0] tmin;
    logic tmin_exit;
    logic [9:0] tmax;
    logic tmax_exit;
  } svc_settings_s;

  typedef struct packed {
    logic valid;
    svc_err_e code;
    logic [1:0] winding;
  } svc_report_s;

endpackage

// ---- rtl/svc_ct_check.sv ----
// Per-winding CT primary rating window against the derived rated current.
// Assumes inputs held stable for one cycle; result registered one cycle later.
module svc_ct_check (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [19:0] power,
  input wire logic [15:0] volt,
  input wire logic [15:0] ctpri,
  output logic ok
);

  logic [47:0] ct_term;
  logic [47:0] rated_term;

  // I_N = S / (sqrt3 * U); compare by cross-multiplication, no divider needed
  assign ct_term = 48'(ctpri) * 48'(volt) * svc_pkg::SQRT3_Q10;
  assign rated_term = 48'(power) * svc_pkg::VA_PER_KVA_Q10;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ok <= 1'b0;
    end else begin
      ok <= ({ct_term[45:0], 2'b00} > rated_term) && (ct_term < {rated_term[46:0], 1'b0});
    end
  end

endmodule // svc_ct_check

// ---- rtl/svc_ext_block.sv ----
// External blocking timer with minimum hold and maximum blocking time.
// Assumes block_in already synchronised; times in 0.1 s steps.
module svc_ext_block #(
  parameter int TICK_CYCLES = svc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic block_in,
  input wire logic [9:0] tmin,
  input wire logic tmin_exit,
  input wire logic [9:0] tmax,
  input wire logic tmax_exit,
  output logic blocked
);

  logic in_d;
  logic [31:0] presc;
  logic tick;
  logic [9:0] min_cnt;
  logic [9:0] max_cnt;
  logic rise;

  assign rise = block_in && !in_d;
  assign tick = (presc == 32'(TICK_CYCLES - 1));

  // Prescaler restarts on each assertion so hold times start cleanly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      presc <= 32'h0;
    end else if (rise || tick) begin
      presc <= 32'h0;
    end else begin
      presc <= presc + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_d <= 1'b0;
    end else begin
      in_d <= block_in;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      min_cnt <= 10'h0;
    end else if (rise) begin
      min_cnt <= tmin_exit ? 10'h0 : tmin;
    end else if (tick && min_cnt != 10'h0) begin
      min_cnt <= min_cnt - 10'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      max_cnt <= 10'h0;
    end else if (rise) begin
      max_cnt <= tmax;
    end else if (tick && block_in && max_cnt != 10'h0) begin
      max_cnt <= max_cnt - 10'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blocked <= 1'b0;
    end else if (block_in || rise) begin
      blocked <= tmax_exit || rise || max_cnt != 10'h0;
    end else begin
      blocked <= min_cnt != 10'h0;
    end
  end

endmodule // svc_ext_block

// ---- rtl/svc_top.sv ----
// Settings validity checker: shadow settings, ordered checks, commit, external blocking.
// Assumes a single-cycle register port from keyboard or interface firmware, one clock.
//
// Our own choices: the strobed register port and the register offsets.
module svc_top #(
  parameter int TICK_CYCLES = svc_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [svc_pkg::ADDR_W-1:0] addr,
  input wire logic [svc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [svc_pkg::DATA_W-1:0] rdata,
  input wire logic ext_block_pin,
  output logic block_low_set_diff_stage,
  output logic block_high_set_diff_stage,
  output logic value_editing_state,
  output svc_pkg::svc_report_s kbd_message,
  output svc_pkg::svc_report_s iface_telegram,
  output svc_pkg::svc_settings_s active_settings
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VALUE_EDITING_STATE = 3'b001,
    ST_RATED = 3'b010,
    ST_WAIT = 3'b011,
    ST_RELATE = 3'b100,
    ST_COMMIT = 3'b101
  } svc_state_e;

  svc_state_e state;
  svc_state_e next_state;
  svc_pkg::svc_settings_s shadow;
  logic three_wdg;
  logic refuse_mode;
  logic src_iface;
  logic [1:0] wdg;
  logic ct_ok;
  logic [15:0] commits;
  svc_pkg::svc_grp_e lock_grp;
  logic cmd_wr;
  logic set_wr;
  logic wr_allowed;
  logic fail;
  svc_pkg::svc_err_e fail_code;
  svc_pkg::svc_err_e rel_code;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_blocked;
  logic [1:0] last_wdg;

  function automatic svc_pkg::svc_grp_e addr_group(input logic [7:0] a);
    case (a)
      svc_pkg::OFS_POWER, svc_pkg::OFS_VOLT_W1, svc_pkg::OFS_VOLT_W2, svc_pkg::OFS_VOLT_W3,
      svc_pkg::OFS_CTPRI_W1, svc_pkg::OFS_CTPRI_W2, svc_pkg::OFS_CTPRI_W3,
      svc_pkg::OFS_CT_SEC: addr_group = svc_pkg::GRP_RATED;
      svc_pkg::OFS_ID0, svc_pkg::OFS_ID2, svc_pkg::OFS_ID10: addr_group = svc_pkg::GRP_CHAR;
      svc_pkg::OFS_EXT_ASSIGN, svc_pkg::OFS_EXT_TMIN,
      svc_pkg::OFS_EXT_TMAX: addr_group = svc_pkg::GRP_EXT;
      default: addr_group = svc_pkg::GRP_NONE;
    endcase
  endfunction

  function automatic svc_pkg::svc_grp_e err_group(input svc_pkg::svc_err_e e);
    case (e)
      svc_pkg::ERR_CT_MISMATCH, svc_pkg::ERR_CT_RATIO,
      svc_pkg::ERR_VOLT_ORDER: err_group = svc_pkg::GRP_RATED;
      svc_pkg::ERR_CHARACTERISTIC: err_group = svc_pkg::GRP_CHAR;
      svc_pkg::ERR_EXT_BLOCK: err_group = svc_pkg::GRP_EXT;
      default: err_group = svc_pkg::GRP_NONE;
    endcase
  endfunction

  assign last_wdg = three_wdg ? 2'd2 : 2'd1;
  assign cmd_wr = wr && addr == svc_pkg::OFS_CMD;
  assign set_wr = wr && addr_group(addr) != svc_pkg::GRP_NONE;
  // Settings are frozen while a check runs so the checked set is the stored set
  assign wr_allowed = (state == ST_IDLE || state == ST_VALUE_EDITING_STATE)
      && (lock_grp == svc_pkg::GRP_NONE || addr_group(addr) == lock_grp);
  assign value_editing_state = state == ST_VALUE_EDITING_STATE;

  svc_ct_check u_ct_check (
    .clk(clk),
    .nrst(nrst),
    .power(shadow.power),
    .volt(shadow.volt[wdg]),
    .ctpri(shadow.ctpri[wdg]),
    .ok(ct_ok)
  );

  // Relations between settings, in fixed priority order
  always_comb begin
    rel_code = svc_pkg::ERR_NONE;
    if (shadow.ct_sec >= svc_pkg::CT_SEC_LIMIT_A) begin
      rel_code = svc_pkg::ERR_CT_RATIO;
    end else if (shadow.volt[0] < shadow.volt[1]) begin
      rel_code = svc_pkg::ERR_VOLT_ORDER;
    end else if (three_wdg && shadow.volt[1] < shadow.volt[2]) begin
      rel_code = svc_pkg::ERR_VOLT_ORDER;
    end else if (shadow.id2 < shadow.id0) begin
      rel_code = svc_pkg::ERR_CHARACTERISTIC;
    end else if ({2'b00, shadow.id2 - shadow.id0, 2'b00} > {2'b00, shadow.id10 - shadow.id2}
        || shadow.id10 < shadow.id2) begin
      // Sector I slope (over 2) must not exceed sector II slope (over 8)
      rel_code = svc_pkg::ERR_CHARACTERISTIC;
    end else if (!shadow.tmin_exit && !shadow.tmax_exit && shadow.tmin > shadow.tmax) begin
      rel_code = svc_pkg::ERR_EXT_BLOCK;
    end
  end

  always_comb begin
    next_state = state;
    fail = 1'b0;
    fail_code = svc_pkg::ERR_NONE;
    case (state)
      ST_IDLE: begin
        if (cmd_wr && wdata[svc_pkg::CMD_STORE_IFACE_BIT]) begin
          next_state = ST_RATED;
        end else if (cmd_wr && wdata[svc_pkg::CMD_VALUE_EDITING_STATE_START_BIT]) begin
          next_state = ST_VALUE_EDITING_STATE;
        end
      end
      ST_VALUE_EDITING_STATE: begin
        if (cmd_wr && wdata[svc_pkg::CMD_STORE_KBD_BIT]) begin
          next_state = ST_RATED;
        end else if (cmd_wr && wdata[svc_pkg::CMD_VALUE_EDITING_STATE_EXIT_BIT]) begin
          next_state = ST_IDLE;
        end
      end
      ST_RATED: next_state = ST_WAIT;
      ST_WAIT: begin
        if (!ct_ok) begin
          fail = 1'b1;
          fail_code = svc_pkg::ERR_CT_MISMATCH;
        end else if (wdg == last_wdg) begin
          next_state = ST_RELATE;
        end else begin
          next_state = ST_RATED;
        end
      end
      ST_RELATE: begin
        if (rel_code != svc_pkg::ERR_NONE) begin
          fail = 1'b1;
          fail_code = rel_code;
        end else begin
          next_state = ST_COMMIT;
        end
      end
      ST_COMMIT: next_state = src_iface ? ST_IDLE : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (fail) begin
      next_state = src_iface ? ST_IDLE : ST_VALUE_EDITING_STATE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_iface <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_RATED) begin
      src_iface <= 1'b1;
    end else if (state == ST_VALUE_EDITING_STATE && next_state == ST_RATED) begin
      src_iface <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdg <= 2'd0;
    end else if (state == ST_WAIT && ct_ok && wdg != last_wdg) begin
      wdg <= wdg + 2'd1;
    end else if (state == ST_IDLE || state == ST_VALUE_EDITING_STATE) begin
      wdg <= 2'd0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      three_wdg <= 1'b1;
      refuse_mode <= 1'b0;
    end else if (wr && addr == svc_pkg::OFS_CTRL && state == ST_IDLE) begin
      three_wdg <= wdata[svc_pkg::CTRL_THREE_WDG_BIT];
      refuse_mode <= wdata[svc_pkg::CTRL_REFUSE_BIT];
    end
  end

  // Shadow settings: written by software, restored from the stored set on value_editing_state exit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadow.power <= svc_pkg::RST_POWER_KVA;
      shadow.volt <= {3{svc_pkg::RST_VOLT_V}};
      shadow.ctpri <= {3{svc_pkg::RST_CTPRI_A}};
      shadow.ct_sec <= svc_pkg::RST_CT_SEC_A;
      shadow.id0 <= svc_pkg::RST_ID0;
      shadow.id2 <= svc_pkg::RST_ID2;
      shadow.id10 <= svc_pkg::RST_ID10;
      shadow.ext_assign <= svc_pkg::RST_EXT_ASSIGN;
      shadow.tmin <= svc_pkg::RST_TMIN;
      shadow.tmin_exit <= 1'b0;
      shadow.tmax <= svc_pkg::RST_TMAX;
      shadow.tmax_exit <= 1'b0;
    end else if (state == ST_VALUE_EDITING_STATE && cmd_wr && wdata[svc_pkg::CMD_VALUE_EDITING_STATE_EXIT_BIT]
        && !wdata[svc_pkg::CMD_STORE_KBD_BIT]) begin
      shadow <= active_settings;
    end else if (set_wr && wr_allowed) begin
      case (addr)
        svc_pkg::OFS_POWER: shadow.power <= wdata[19:0];
        svc_pkg::OFS_VOLT_W1: shadow.volt[0] <= wdata[15:0];
        svc_pkg::OFS_VOLT_W2: shadow.volt[1] <= wdata[15:0];
        svc_pkg::OFS_VOLT_W3: shadow.volt[2] <= wdata[15:0];
        svc_pkg::OFS_CTPRI_W1: shadow.ctpri[0] <= wdata[15:0];
        svc_pkg::OFS_CTPRI_W2: shadow.ctpri[1] <= wdata[15:0];
        svc_pkg::OFS_CTPRI_W3: shadow.ctpri[2] <= wdata[15:0];
        svc_pkg::OFS_CT_SEC: shadow.ct_sec <= wdata[7:0];
        svc_pkg::OFS_ID0: shadow.id0 <= wdata[11:0];
        svc_pkg::OFS_ID2: shadow.id2 <= wdata[11:0];
        svc_pkg::OFS_ID10: shadow.id10 <= wdata[11:0];
        svc_pkg::OFS_EXT_ASSIGN: shadow.ext_assign <= wdata[1:0];
        svc_pkg::OFS_EXT_TMIN: begin
          shadow.tmin <= wdata[9:0];
          shadow.tmin_exit <= wdata[svc_pkg::EXT_TIME_EXIT_BIT];
        end
        svc_pkg::OFS_EXT_TMAX: begin
          shadow.tmax <= wdata[9:0];
          shadow.tmax_exit <= wdata[svc_pkg::EXT_TIME_EXIT_BIT];
        end
        default: shadow <= shadow;
      endcase
    end
  end

  // Only a fully checked set reaches the live settings
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_settings.power <= svc_pkg::RST_POWER_KVA;
      active_settings.volt <= {3{svc_pkg::RST_VOLT_V}};
      active_settings.ctpri <= {3{svc_pkg::RST_CTPRI_A}};
      active_settings.ct_sec <= svc_pkg::RST_CT_SEC_A;
      active_settings.id0 <= svc_pkg::RST_ID0;
      active_settings.id2 <= svc_pkg::RST_ID2;
      active_settings.id10 <= svc_pkg::RST_ID10;
      active_settings.ext_assign <= svc_pkg::RST_EXT_ASSIGN;
      active_settings.tmin <= svc_pkg::RST_TMIN;
      active_settings.tmin_exit <= 1'b0;
      active_settings.tmax <= svc_pkg::RST_TMAX;
      active_settings.tmax_exit <= 1'b0;
    end else if (state == ST_COMMIT) begin
      active_settings <= shadow;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      commits <= 16'h0;
    end else if (state == ST_COMMIT) begin
      commits <= commits + 16'h1;
    end
  end

  // Keyboard message stays until the next store attempt or value_editing_state exit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kbd_message <= '0;
      lock_grp <= svc_pkg::GRP_NONE;
    end else if (fail && !src_iface) begin
      kbd_message.valid <= 1'b1;
      kbd_message.code <= fail_code;
      kbd_message.winding <= wdg;
      lock_grp <= refuse_mode ? err_group(fail_code) : svc_pkg::GRP_NONE;
    end else if (state == ST_RATED || state == ST_IDLE) begin
      kbd_message.valid <= 1'b0;
      lock_grp <= svc_pkg::GRP_NONE;
    end
  end

  // Telegram is a one-cycle answer to the interface host
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      iface_telegram <= '0;
    end else if (fail && src_iface) begin
      iface_telegram.valid <= 1'b1;
      iface_telegram.code <= fail_code;
      iface_telegram.winding <= wdg;
    end else begin
      iface_telegram.valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        svc_pkg::OFS_CTRL: rdata <= 32'({refuse_mode, three_wdg});
        svc_pkg::OFS_STATUS: rdata <= {commits, 6'h0, kbd_message.winding, 1'b0,
            kbd_message.code, 1'b0, kbd_message.valid,
            (state != ST_IDLE && state != ST_VALUE_EDITING_STATE), value_editing_state};
        svc_pkg::OFS_POWER: rdata <= 32'(shadow.power);
        svc_pkg::OFS_VOLT_W1: rdata <= 32'(shadow.volt[0]);
        svc_pkg::OFS_VOLT_W2: rdata <= 32'(shadow.volt[1]);
        svc_pkg::OFS_VOLT_W3: rdata <= 32'(shadow.volt[2]);
        svc_pkg::OFS_CTPRI_W1: rdata <= 32'(shadow.ctpri[0]);
        svc_pkg::OFS_CTPRI_W2: rdata <= 32'(shadow.ctpri[1]);
        svc_pkg::OFS_CTPRI_W3: rdata <= 32'(shadow.ctpri[2]);
        svc_pkg::OFS_CT_SEC: rdata <= 32'(shadow.ct_sec);
        svc_pkg::OFS_ID0: rdata <= 32'(shadow.id0);
        svc_pkg::OFS_ID2: rdata <= 32'(shadow.id2);
        svc_pkg::OFS_ID10: rdata <= 32'(shadow.id10);
        svc_pkg::OFS_EXT_ASSIGN: rdata <= 32'(shadow.ext_assign);
        svc_pkg::OFS_EXT_TMIN: rdata <= 32'({shadow.tmin_exit, 5'h0, shadow.tmin});
        svc_pkg::OFS_EXT_TMAX: rdata <= 32'({shadow.tmax_exit, 5'h0, shadow.tmax});
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // Blocking input is asynchronous to clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
    end else begin
      ext_sync1 <= ext_block_pin;
      ext_sync2 <= ext_sync1;
    end
  end

  svc_ext_block #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_ext_block (
    .clk(clk),
    .nrst(nrst),
    .block_in(ext_sync2),
    .tmin(active_settings.tmin),
    .tmin_exit(active_settings.tmin_exit),
    .tmax(active_settings.tmax),
    .tmax_exit(active_settings.tmax_exit),
    .blocked(ext_blocked)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      block_low_set_diff_stage <= 1'b0;
      block_high_set_diff_stage <= 1'b0;
    end else begin
      // Stage A is low-set, stage B high-set
      block_low_set_diff_stage <= ext_blocked
          && active_settings.ext_assign[svc_pkg::EXT_ASSIGN_LOW_BIT];
      block_high_set_diff_stage <= ext_blocked
          && active_settings.ext_assign[svc_pkg::EXT_ASSIGN_HIGH_BIT];
    end
  end

endmodule // svc_top

// ---- test/svc_host.sv ----
// Host model: keyboard or interface firmware on the register port.
// Assumes the slave never stalls; read data stand one cycle after rd.
module svc_host (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Extra edge after each strobe so a strobe is never set twice at one step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
endmodule // svc_host

// ---- test/svc_props.sv ----
// Port checks for the settings validity checker.
// Assumes one clock domain; bound into every svc_top instance.
module svc_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rd,
  input wire logic [svc_pkg::DATA_W-1:0] rdata,
  input wire logic ext_block_pin,
  input wire logic block_low_set_diff_stage,
  input wire logic block_high_set_diff_stage,
  input wire logic value_editing_state,
  input wire svc_pkg::svc_report_s kbd_message,
  input wire svc_pkg::svc_report_s iface_telegram,
  input wire svc_pkg::svc_settings_s active_settings
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Pin held through the two sync stages and the timer load
  sequence s_pin_rise;
    $rose(ext_block_pin) ##1 ext_block_pin [*4];
  endsequence
  sequence s_kbd_fail;
    $rose(kbd_message.valid);
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == '0)
    else $error("read data not zero outside a read");
  a_tel_pulse: assert property (iface_telegram.valid |=> !iface_telegram.valid)
    else $error("telegram longer than one cycle");
  a_tel_code: assert property (iface_telegram.valid |-> iface_telegram.code != svc_pkg::ERR_NONE)
    else $error("telegram without error code");
  a_tel_idle: assert property (iface_telegram.valid |-> !value_editing_state)
    else $error("telegram while editing");
  a_kbd_code: assert property (kbd_message.valid |-> kbd_message.code != svc_pkg::ERR_NONE)
    else $error("message without error code");
  a_kbd_value_editing_state: assert property (s_kbd_fail |-> value_editing_state)
    else $error("value_editing_state state left after failure");
  a_commit_clean: assert property ($changed(active_settings)
    |-> !kbd_message.valid && !iface_telegram.valid)
    else $error("settings stored beside a failure");
  a_block_low: assert property (s_pin_rise ##0 active_settings.ext_assign[0]
    |-> ##[0:1] block_low_set_diff_stage)
    else $error("stage A not blocked");
  a_block_high: assert property (s_pin_rise ##0 active_settings.ext_assign[1]
    |-> ##[0:1] block_high_set_diff_stage)
    else $error("stage B not blocked");
endmodule // svc_props

bind svc_top svc_props u_props (
  .clk(clk), .nrst(nrst), .rd(rd), .rdata(rdata), .ext_block_pin(ext_block_pin),
  .block_low_set_diff_stage(block_low_set_diff_stage),
  .block_high_set_diff_stage(block_high_set_diff_stage),
  .value_editing_state(value_editing_state), .kbd_message(kbd_message),
  .iface_telegram(iface_telegram), .active_settings(active_settings)
);

// ---- test/svc_top_tb.sv ----
// Self-checking bench for the settings validity checker.
// Assumes a time step shortened to 10 cycles and the package register map.
module svc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic nrst;
  logic pin;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic lo;
  logic hi;
  logic ed;
  svc_pkg::svc_report_s kbd;
  svc_pkg::svc_report_s tel;
  svc_pkg::svc_settings_s act;
  int num_errors = 0;
  int checked = 0;
  logic [31:0] rv;
  svc_top #(.TICK_CYCLES(10)) dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_block_pin(pin), .block_low_set_diff_stage(lo),
    .block_high_set_diff_stage(hi), .value_editing_state(ed), .kbd_message(kbd),
    .iface_telegram(tel), .active_settings(act));
  svc_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Store command, then watch a fixed window for a report
  task automatic store(input int b, input logic [2:0] ec, input logic [1:0] ew);
    svc_pkg::svc_report_s r;
    r = '0;
    host.wr_reg(svc_pkg::OFS_CMD, 32'h1 << b);
    repeat (12) begin
      @(posedge clk);
      #1;
      if (tel.valid === 1'b1) r = tel;
      else if (kbd.valid === 1'b1) r = kbd;
    end
    check("code", 32'(r.code), 32'(ec));
    if (ec == 3'h1) check("winding", 32'(r.winding), 32'(ew));
  endtask
  task automatic sc_defaults();
    check("power", 32'(act.power), 32'(svc_pkg::RST_POWER_KVA));
    host.rd_reg(svc_pkg::OFS_EXT_TMAX, rv);
    check("tmax", rv, 32'(svc_pkg::RST_TMAX));
    host.rd_reg(8'h44, rv);
    check("unmapped", rv, 32'h0);
  endtask
  task automatic sc_iface();
    logic [7:0] a [5] = '{8'h20, 8'h28, 8'h14, 8'h30, 8'h3c};
    logic [31:0] bad [5] = '{32'h64, 32'h5, 32'h1b58, 32'ha, 32'h1e};
    logic [31:0] good [5] = '{32'h5dc, 32'h1, 32'h19c8, 32'h28, 32'h1};
    svc_pkg::svc_settings_s keep;
    keep = act;
    for (int i = 0; i < 5; i++) begin
      host.wr_reg(a[i], bad[i]);
      store(3, 3'(i + 1), 2'h1);
      check("kept", 32'(act === keep), 32'h1);
      host.wr_reg(a[i], good[i]);
    end
    host.wr_reg(svc_pkg::OFS_CTPRI_W3, 32'h64);
    host.wr_reg(svc_pkg::OFS_CT_SEC, 32'h5);
    store(3, 3'h1, 2'h2);
    host.wr_reg(svc_pkg::OFS_CTPRI_W3, 32'h5dc);
    host.wr_reg(svc_pkg::OFS_CT_SEC, 32'h1);
    host.wr_reg(svc_pkg::OFS_ID2, 32'h14);
    store(3, 3'h0, 2'h0);
    check("id2", 32'(act.id2), 32'h14);
  endtask
  task automatic sc_kbd();
    host.wr_reg(svc_pkg::OFS_CMD, 32'h1);
    check("value_editing_state", 32'(ed), 32'h1);
    host.wr_reg(svc_pkg::OFS_VOLT_W3, 32'h1b58);
    store(2, 3'h3, 2'h0);
    check("value_editing_state kept", 32'(ed), 32'h1);
    host.wr_reg(svc_pkg::OFS_VOLT_W3, 32'h19c8);
    store(2, 3'h0, 2'h0);
    check("value_editing_state left", 32'(ed), 32'h0);
    host.wr_reg(svc_pkg::OFS_CTRL, 32'h0);
    host.wr_reg(svc_pkg::OFS_VOLT_W3, 32'h1b58);
    store(3, 3'h0, 2'h0);
    // Refuse mode: a rated-group failure locks out characteristic writes
    host.wr_reg(svc_pkg::OFS_CTRL, 32'h3);
    host.wr_reg(svc_pkg::OFS_CMD, 32'h1);
    store(2, 3'h3, 2'h0);
    host.wr_reg(svc_pkg::OFS_ID2, 32'h1e);
    host.rd_reg(svc_pkg::OFS_ID2, rv);
    check("refused", rv, 32'h14);
    host.rd_reg(svc_pkg::OFS_STATUS, rv);
    check("status", rv, 32'h0004_0235);
  endtask
  task automatic sc_block();
    pin <= 1'b1;
    cyc(2);
    pin <= 1'b0;
    cyc(5);
    check("min hold", 32'({lo, hi}), 32'h3);
    cyc(13);
    check("min end", 32'({lo, hi}), 32'h0);
    pin <= 1'b1;
    cyc(150);
    check("max run", 32'(lo), 32'h1);
    cyc(80);
    check("max end", 32'(lo), 32'h0);
    pin <= 1'b0;
    host.wr_reg(svc_pkg::OFS_EXT_ASSIGN, 32'h1);
    host.wr_reg(svc_pkg::OFS_EXT_TMAX, 32'h8000);
    store(3, 3'h0, 2'h0);
    pin <= 1'b1;
    cyc(250);
    check("latched", 32'({lo, hi}), 32'h2);
    pin <= 1'b0;
    cyc(30);
    check("released", 32'(lo), 32'h0);
    // Back to a finite maximum, else the hold-time order check never trips
    host.wr_reg(svc_pkg::OFS_EXT_TMAX, 32'(svc_pkg::RST_TMAX));
  endtask
  initial begin
    nrst = 1'b0;
    pin = 1'b0;
    cyc(10);
    nrst <= 1'b1;
    cyc(1);
    sc_defaults();
    sc_block();
    sc_iface();
    sc_kbd();
    summarize();
  end
endmodule // svc_top_tb
